/* hdl/gsm_pin_mux.sv */
// Pin 2 output-source multiplexer with AXI4-Lite register slave
// Summary of operation
// - Five-bit pin 2 selector, read/write, resets zero
// - Selected source reaches pin only as output
// - Code 0 low, 1 processor pin, 12-13 and 28-31 zero
// - Code 2 routes software level bit
// - Codes 3-5 route auto-mute flags
// - Code 6 ORs three clock faults
// - Code 7 routes serial audio output data
// - Codes 8-9 route active-low analog mutes
// - Code 10 lock flag, 11 pump clock
// - Codes 14-15 route soft-silence thresholds
// - Codes 16-17 divided PLL, oscillator clocks
// - Codes 18-19 impedance-sense flags
// - Code 20 low while supply fails
// - Code 21 high during offset calibration
// - Codes 22-25 clock error, change, miss, halt
// - Code 26 boot done, 27 pump valid
// - Level bit 5 drives pin 2
// - Level bit 4 drives mute pin
// - Level bit 3 drives pin 0
// - Polarity bit 5 inverts pin 2
//
// The AXI4-Lite register port was chosen for this implementation.
module gsm_pin_mux
  import gsm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Internal sources
  input  wire gsm_src_t    src,
  // Pin 2, two-way
  input  wire logic        pin2_in,
  output logic             pin2_out,
  output logic             pin2_oe,
  // Software levels for the other pins
  output logic             mute_software_level,
  output logic             pin0_software_level
);
  // All state in one struct
  typedef struct packed {
    gsm_wr_t     wst;      // Write channel state
    logic        aw_got;   // Write address held
    logic        w_got;    // Write data held
    logic [11:0] awaddr;   // Held write address
    logic [7:0]  wdata;    // Held low byte of write data
    logic        wlane0;   // Low byte lane enabled
    logic [1:0]  bresp;    // Write answer
    logic        rvalid;   // Read answer pending
    logic [1:0]  rresp;    // Read answer code
    logic [7:0]  rdata;    // Read data, low byte
    logic [4:0]  sel2;     // pin2_source_code
    logic        lvl2;     // pin2_software_level
    logic        lvl_mute; // Mute pin software level
    logic        lvl0;     // pin0_software_level
    logic        inv2;     // Pin 2 polarity
    logic        dir2;     // Pin 2 drives when set
    logic        pin2_q;   // Registered pin 2 level
  } gsm_st_t;

  gsm_st_t    st_ff;
  gsm_st_t    nxt_st;
  logic       mux_q;      // Selected source, registered in the mux
  logic       wr_fire;    // Held write committed this cycle
  logic       wr_ok;      // Held write address is mapped
  logic [7:0] widx;       // Held write register index
  logic [7:0] ridx;       // Read register index
  logic       rd_ok;      // Read address is mapped
  logic [7:0] rval;       // Read value of addressed register

  // Source selection and its divided clocks
  gsm_src_mux u_src_mux (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .code      (st_ff.sel2),
    .reg_level (st_ff.lvl2),
    .src       (src),
    .q         (mux_q)
  );

  // Address decode: index sits in bits 9:2, bits 11:10 must be zero
  assign widx    = st_ff.awaddr[9:2];
  assign ridx    = s_axi_araddr[9:2];
  assign wr_ok   = (st_ff.awaddr[11:10] == 2'h0) &&
                   (widx == IDX_SEL2 || widx == IDX_LVL ||
                    widx == IDX_INV  || widx == IDX_DIR);
  assign rd_ok   = (s_axi_araddr[11:10] == 2'h0) &&
                   (ridx == IDX_SEL2 || ridx == IDX_LVL ||
                    ridx == IDX_INV  || ridx == IDX_DIR);
  assign wr_fire = (st_ff.wst == WR_IDLE) && st_ff.aw_got && st_ff.w_got;

  // Read mux; reserved bits read zero
  always_comb begin
    rval = 8'h00;
    if (ridx == IDX_SEL2) begin
      rval[SEL_MSB:0] = st_ff.sel2;
    end else if (ridx == IDX_LVL) begin
      rval[LVL2_BIT] = st_ff.lvl2;
      rval[MUTE_BIT] = st_ff.lvl_mute;
      rval[LVL0_BIT] = st_ff.lvl0;
    end else if (ridx == IDX_INV) begin
      rval[INV2_BIT] = st_ff.inv2;
    end else if (ridx == IDX_DIR) begin
      rval[DIR2_BIT] = st_ff.dir2;
    end
  end

  // Next state: bus channels, registers, pin
  always_comb begin
    nxt_st = st_ff;
    // Address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.wdata  = s_axi_wdata[7:0];
      nxt_st.wlane0 = s_axi_wstrb[0];
    end
    case (st_ff.wst)
      WR_IDLE: begin
        // Commit once both halves are held
        if (wr_fire) begin
          nxt_st.aw_got = 1'b0;
          nxt_st.w_got  = 1'b0;
          nxt_st.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
          nxt_st.wst    = WR_RESP;
          if (wr_ok && st_ff.wlane0) begin
            case (widx)
              IDX_SEL2: nxt_st.sel2 = st_ff.wdata[SEL_MSB:0];
              IDX_LVL: begin
                nxt_st.lvl2     = st_ff.wdata[LVL2_BIT];
                nxt_st.lvl_mute = st_ff.wdata[MUTE_BIT];
                nxt_st.lvl0     = st_ff.wdata[LVL0_BIT];
              end
              IDX_INV: nxt_st.inv2 = st_ff.wdata[INV2_BIT];
              IDX_DIR: nxt_st.dir2 = st_ff.wdata[DIR2_BIT];
              default: nxt_st.sel2 = st_ff.sel2;
            endcase
          end
        end
      end
      WR_RESP: begin
        // Answer stands until the master takes it
        if (s_axi_bready) begin
          nxt_st.wst = WR_IDLE;
        end
      end
      default: nxt_st.wst = WR_IDLE;
    endcase
    // One read at a time; the answer stands until taken
    if (st_ff.rvalid) begin
      if (s_axi_rready) begin
        nxt_st.rvalid = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_ok ? rval : 8'h00;
      nxt_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // Polarity applies to every source, the level bit included
    nxt_st.pin2_q = mux_q ^ st_ff.inv2;
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '{wst: WR_IDLE, sel2: SEL_RST, lvl2: BIT_RST,
                 lvl_mute: BIT_RST, lvl0: BIT_RST, inv2: BIT_RST,
                 dir2: BIT_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Handshake outputs
  assign s_axi_awready = (st_ff.wst == WR_IDLE) && !st_ff.aw_got;
  assign s_axi_wready  = (st_ff.wst == WR_IDLE) && !st_ff.w_got;
  assign s_axi_bvalid  = (st_ff.wst == WR_RESP);
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rresp   = st_ff.rresp;
  assign s_axi_rdata   = {24'h000000, st_ff.rdata};

  // Pin: level always computed, driven only as an output
  assign pin2_out = st_ff.pin2_q;
  assign pin2_oe  = st_ff.dir2;

  // Levels for pins whose selectors live elsewhere
  assign mute_software_level = st_ff.lvl_mute;
  assign pin0_software_level = st_ff.lvl0;

  // Pin 2 is read back by nobody here; kept for the pad
  logic unused_pin2_in;
  assign unused_pin2_in = pin2_in;

  // Checks
  property p_sel_wr;
    @(posedge clk) disable iff (sys_rst)
    wr_fire && wr_ok && st_ff.wlane0 && widx == IDX_SEL2
      |=> st_ff.sel2 == $past(st_ff.wdata[SEL_MSB:0]);
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("selector not written");
  property p_oe;
    @(posedge clk) disable iff (sys_rst)
    pin2_oe == st_ff.dir2 && (st_ff.dir2 == $past(st_ff.dir2) || wr_fire
      || $past(wr_fire));
  endproperty
  a_oe: assert property (p_oe)
    else $error("enable not from direction");
  property p_off;
    @(posedge clk) disable iff (sys_rst)
    st_ff.sel2 == C_OFF && !wr_fire ##1 !wr_fire
      |=> pin2_out == $past(st_ff.inv2);
  endproperty
  a_off: assert property (p_off)
    else $error("code zero not low");
  property p_reg;
    @(posedge clk) disable iff (sys_rst)
    st_ff.sel2 == C_REG && !wr_fire ##1 !wr_fire
      |=> pin2_out == ($past(st_ff.lvl2, 2) ^ $past(st_ff.inv2));
  endproperty
  a_reg: assert property (p_reg)
    else $error("software level not on pin");
  property p_inv;
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> pin2_out == ($past(mux_q) ^ $past(st_ff.inv2));
  endproperty
  a_inv: assert property (p_inv)
    else $error("polarity wrong");
  property p_mute;
    @(posedge clk) disable iff (sys_rst)
    wr_fire && wr_ok && st_ff.wlane0 && widx == IDX_LVL
      |=> mute_software_level == $past(st_ff.wdata[MUTE_BIT])
       && pin0_software_level == $past(st_ff.wdata[LVL0_BIT]);
  endproperty
  a_mute: assert property (p_mute)
    else $error("pin levels not written");
  property p_bhold;
    @(posedge clk) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped");
  property p_rerr;
    @(posedge clk) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready && !rd_ok
      |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR;
  endproperty
  a_rerr: assert property (p_rerr)
    else $error("unmapped read not refused");
  c_wr:  cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
  c_rd:  cover property (@(posedge clk) s_axi_rvalid && s_axi_rready);
  c_pin: cover property (@(posedge clk) pin2_oe && $rose(pin2_out));
  c_inv: cover property (@(posedge clk) st_ff.inv2 && st_ff.sel2 == C_REG);
endmodule : gsm_pin_mux

/* include/gsm_pkg.sv */
// Package: register map, source codes and carrier types of the pin 2 mux
package gsm_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [7:0] IDX_DIR  = 8'h08; // Pin direction control
  localparam logic [7:0] IDX_SEL2 = 8'h55; // pin2_source_select
  localparam logic [7:0] IDX_LVL  = 8'h56; // software_pin_levels
  localparam logic [7:0] IDX_INV  = 8'h57; // Output polarity
  // Field positions
  localparam int SEL_MSB  = 4;
  localparam int LVL2_BIT = 5;
  localparam int MUTE_BIT = 4;
  localparam int LVL0_BIT = 3;
  localparam int INV2_BIT = 5;
  localparam int DIR2_BIT = 2;
  // Values after reset
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic       BIT_RST = 1'b0;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Divider: one output period per four input periods
  localparam logic [1:0] DIV_RST = 2'h0;
  // Source codes for pin 2
  localparam logic [4:0] C_OFF    = 5'h00;
  localparam logic [4:0] C_DSP    = 5'h01;
  localparam logic [4:0] C_REG    = 5'h02;
  localparam logic [4:0] C_AMUTE  = 5'h03;
  localparam logic [4:0] C_AMUTEL = 5'h04;
  localparam logic [4:0] C_AMUTER = 5'h05;
  localparam logic [4:0] C_CLKINV = 5'h06;
  localparam logic [4:0] C_SDO    = 5'h07;
  localparam logic [4:0] C_ANAML  = 5'h08;
  localparam logic [4:0] C_ANAMR  = 5'h09;
  localparam logic [4:0] C_LOCK   = 5'h0a;
  localparam logic [4:0] C_CPCLK  = 5'h0b;
  localparam logic [4:0] C_RSV0   = 5'h0c;
  localparam logic [4:0] C_RSV1   = 5'h0d;
  localparam logic [4:0] C_UVHI   = 5'h0e;
  localparam logic [4:0] C_UVLO   = 5'h0f;
  localparam logic [4:0] C_PLLD4  = 5'h10;
  localparam logic [4:0] C_OSCD4  = 5'h11;
  localparam logic [4:0] C_IMPL   = 5'h12;
  localparam logic [4:0] C_IMPR   = 5'h13;
  localparam logic [4:0] C_SUPPLY = 5'h14;
  localparam logic [4:0] C_OFSCAL = 5'h15;
  localparam logic [4:0] C_CERR   = 5'h16;
  localparam logic [4:0] C_CCHG   = 5'h17;
  localparam logic [4:0] C_CMISS  = 5'h18;
  localparam logic [4:0] C_CHALT  = 5'h19;
  localparam logic [4:0] C_BOOT   = 5'h1a;
  localparam logic [4:0] C_CPVLD  = 5'h1b;
  // Write channel states
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } gsm_wr_t;
  // Internal sources offered to pin 2
  typedef struct packed {
    logic dsp_pin2;     // Signal processor pin 2 output
    logic automute_l;   // Left auto-mute
    logic automute_r;   // Right auto-mute
    logic clk_err;      // Clock error
    logic clk_chg;      // Clock changing
    logic clk_miss;     // Clock missing
    logic clk_halt;     // Clock halt detected
    logic sdo;          // serial_audio_out_data
    logic anamute_l_n;  // Left analog mute, active low
    logic anamute_r_n;  // Right analog mute, active low
    logic pll_lock;     // PLL locked
    logic cp_clk;       // Charge pump clock
    logic uv_hi;        // soft_silence_pin above high threshold
    logic uv_lo;        // soft_silence_pin above low threshold
    logic pll_clk;      // PLL clock, sampled
    logic osc_clk;      // Oscillator clock, sampled
    logic imp_l;        // Left impedance sense
    logic imp_r;        // Right impedance sense
    logic supply_fail;  // Supply monitor fail indication
    logic offs_cal;     // Offset calibration running
    logic boot_done;    // Signal processor boot done
    logic cp_valid_n;   // Charge pump output valid, active low
  } gsm_src_t;
endpackage : gsm_pkg

/* hdl/gsm_src_mux.sv */
// Source selector for pin 2 with the two divide-by-four clocks
module gsm_src_mux
  import gsm_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     sys_rst,
  // Selection
  input  wire logic [4:0] code,
  input  wire logic     reg_level,
  input  wire gsm_src_t src,
  // Selected level
  output logic          q
);
  // All state in one struct
  typedef struct packed {
    logic [1:0]      prev;  // Last sample of pll/osc clocks
    logic [1:0][1:0] cnt;   // Rising-edge counters
    logic            q;     // Registered selection
  } gsm_mux_st_t;

  gsm_mux_st_t st_ff;
  gsm_mux_st_t nxt_st;
  logic [1:0]  clk_in;
  logic        sel;

  assign clk_in = {src.osc_clk, src.pll_clk};

  // Next state: dividers and selection
  always_comb begin
    nxt_st = st_ff;
    // Counter bit 1 toggles every second rising edge: input / 4
    for (int i = 0; i < 2; i++) begin
      nxt_st.prev[i] = clk_in[i];
      if (clk_in[i] && !st_ff.prev[i]) begin
        nxt_st.cnt[i] = st_ff.cnt[i] + 2'h1;
      end
    end
    case (code)
      C_OFF:    sel = 1'b0;
      C_DSP:    sel = src.dsp_pin2;
      C_REG:    sel = reg_level;
      C_AMUTE:  sel = src.automute_l & src.automute_r;
      C_AMUTEL: sel = src.automute_l;
      C_AMUTER: sel = src.automute_r;
      C_CLKINV: sel = src.clk_err | src.clk_chg | src.clk_miss;
      C_SDO:    sel = src.sdo;
      C_ANAML:  sel = src.anamute_l_n;
      C_ANAMR:  sel = src.anamute_r_n;
      C_LOCK:   sel = src.pll_lock;
      C_CPCLK:  sel = src.cp_clk;
      C_UVHI:   sel = src.uv_hi;
      C_UVLO:   sel = src.uv_lo;
      C_PLLD4:  sel = st_ff.cnt[0][1];
      C_OSCD4:  sel = st_ff.cnt[1][1];
      C_IMPL:   sel = src.imp_l;
      C_IMPR:   sel = src.imp_r;
      C_SUPPLY: sel = ~src.supply_fail;
      C_OFSCAL: sel = src.offs_cal;
      C_CERR:   sel = src.clk_err;
      C_CCHG:   sel = src.clk_chg;
      C_CMISS:  sel = src.clk_miss;
      C_CHALT:  sel = src.clk_halt;
      C_BOOT:   sel = src.boot_done;
      C_CPVLD:  sel = src.cp_valid_n;
      // Reserved 0x0c/0x0d and all others are held low
      default:  sel = 1'b0;
    endcase
    nxt_st.q = sel;
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;

  // Checks on the selection
  property p_clkinv;
    @(posedge clk) disable iff (sys_rst)
    code == C_CLKINV |=> q == $past(src.clk_err | src.clk_chg | src.clk_miss);
  endproperty
  a_clkinv: assert property (p_clkinv)
    else $error("clock invalid flag wrong");
  property p_supply;
    @(posedge clk) disable iff (sys_rst)
    code == C_SUPPLY && src.supply_fail |=> !q;
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply low flag not low");
  property p_rsv;
    @(posedge clk) disable iff (sys_rst)
    code == C_RSV0 || code == C_RSV1 || code > C_CPVLD |=> !q;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved code not low");
  property p_amute;
    @(posedge clk) disable iff (sys_rst)
    code == C_AMUTE |=> q == $past(src.automute_l && src.automute_r);
  endproperty
  a_amute: assert property (p_amute)
    else $error("auto-mute flag wrong");
endmodule : gsm_src_mux

/* verification/gsm_board_model.sv */
// Board-side reader of pin 2: pull-down pad and rise counter
module gsm_board_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Pin 2 as driven by the device
  input  wire logic       pin2_out,
  input  wire logic       pin2_oe,
  // Counter clear from the bench
  input  wire logic       clr,
  // What the board sees
  output logic            pad,
  output logic [7:0]      rises_ff
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_ff; // Pad one edge back

  // Board pull-down: a released pad reads low, never the last level
  assign pad = pin2_oe ? pin2_out : 1'b0;

  // Count rising pad edges; sampling at clk limits it to slow toggles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_ff  <= 1'b0;
      rises_ff <= 8'h00;
    end else begin
      last_ff <= pad;
      if (clr) begin
        rises_ff <= 8'h00;
      end else if (pad && !last_ff) begin
        rises_ff <= rises_ff + 8'h01;
      end
    end
  end
endmodule : gsm_board_model

/* verification/gsm_pin_mux_tb_top.sv */
// Self-checking bench for the pin 2 output-source mux
module gsm_pin_mux_tb_top;
  import gsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Expected result note: kind 3 means rise count, else value
  typedef struct packed {
    logic [1:0]  k;
    logic [33:0] e;
  } gsm_note_t;

  logic        clk, sys_rst, chk, clr, pad, lvl, inv;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pin2_out, pin2_oe;
  logic        mute_software_level, pin0_software_level;
  logic [7:0]  rises_ff;
  logic [4:0]  c;
  gsm_src_t    src;
  gsm_note_t   q[$];
  int          n_errors, n_tests, cyc, seed;

  gsm_pin_mux i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src, .pin2_in(pad),
    .pin2_out, .pin2_oe, .mute_software_level, .pin0_software_level);
  gsm_board_model i_board (.clk, .sys_rst, .pin2_out, .pin2_oe, .clr,
    .pad, .rises_ff);

  // 100 MHz clock
  always #5 clk = ~clk;

  // Byte address from register index
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction : ad

  // Expected pin level per code; divided clocks are checked apart
  function automatic logic pick(input logic [4:0] k, input gsm_src_t s,
                                input logic l);
    logic [31:0] t;
    t = {4'h0, s.cp_valid_n, s.boot_done,
         s.clk_halt, s.clk_miss, s.clk_chg, s.clk_err,
         s.offs_cal, ~s.supply_fail, s.imp_r, s.imp_l,
         2'b00, s.uv_lo, s.uv_hi, 2'b00,
         s.cp_clk, s.pll_lock, s.anamute_r_n, s.anamute_l_n,
         s.sdo, s.clk_err | s.clk_chg | s.clk_miss,
         s.automute_r, s.automute_l, s.automute_l & s.automute_r,
         l, s.dsp_pin2, 1'b0};
    return t[k];
  endfunction : pick

  // Verdict and end of run
  task automatic results;
    $display("Checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Oldest note against what was seen
  task automatic cmp(input string nm, input logic [33:0] seen);
    gsm_note_t n;
    n = (q.size() > 0) ? q.pop_front() : '1;
    n_tests++;
    if (n.e !== seen) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, n.e, seen);
    end
  endtask : cmp

  // Bus write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] i, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    q.push_back({2'd1, 34'(r)});
    s_axi_awaddr  <= ad(i);
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    // Idle edge, so a next call never re-drives bready in this step
    @(posedge clk);
  endtask : wr

  // Bus read, expected {rresp, rdata}
  task automatic rd(input logic [7:0] i, input logic [31:0] d,
                    input logic [1:0] r);
    q.push_back({2'd0, r, d});
    s_axi_araddr  <= ad(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    // Idle edge, so a next call never re-drives rready in this step
    @(posedge clk);
  endtask : rd

  // Let the pin path settle, then strobe a pin check
  task automatic pin(input logic [1:0] k, input logic [33:0] e);
    repeat (4) @(posedge clk);
    q.push_back({k, e});
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask : pin

  // Monitor: takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp("rdata", {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", 34'(s_axi_bresp));
    if (chk) cmp("pins", (q.size() > 0 && q[0].k == 2'd3) ? 34'(rises_ff)
      : 34'({mute_software_level, pin0_software_level, pad}));
  end

  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      results();
    end
  end

  // Main sequence
  initial begin
    {clk, chk, clr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, src} = '0;
    {n_errors, n_tests, cyc} = '0;
    seed = 32'h645d;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IDX_SEL2, 32'h0, RESP_OKAY);
    rd(IDX_LVL, 32'h0, RESP_OKAY);
    rd(IDX_INV, 32'h0, RESP_OKAY);
    // Reserved bits are dropped and read zero
    wr(IDX_SEL2, 8'hff, 4'hf, RESP_OKAY);
    rd(IDX_SEL2, 32'h1f, RESP_OKAY);
    wr(IDX_LVL, 8'hff, 4'hf, RESP_OKAY);
    rd(IDX_LVL, 32'h38, RESP_OKAY);
    wr(IDX_INV, 8'hff, 4'hf, RESP_OKAY);
    rd(IDX_INV, 32'h20, RESP_OKAY);
    // Pin still an input: inverted zero must not reach the pad
    pin(2'd2, 34'(3'b110));
    // Write without byte strobe changes nothing
    wr(IDX_SEL2, 8'h02, 4'h0, RESP_OKAY);
    rd(IDX_SEL2, 32'h1f, RESP_OKAY);
    // Unmapped index answers with an error
    wr(8'h30, 8'hff, 4'hf, RESP_SLVERR);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(IDX_DIR, 8'h04, 4'hf, RESP_OKAY);
    rd(IDX_DIR, 32'h4, RESP_OKAY);
    // Every code but 16-17 twice with random sources, level and polarity
    for (int i = 0; i < 64; i++) begin
      c = i[4:0];
      if (c == C_PLLD4 || c == C_OSCD4) continue;
      src <= gsm_src_t'(22'($random(seed)));
      lvl = 1'($random(seed));
      inv = 1'($random(seed));
      wr(IDX_SEL2, {3'b000, c}, 4'hf, RESP_OKAY);
      wr(IDX_LVL, {2'b00, lvl, 5'h00}, 4'hf, RESP_OKAY);
      wr(IDX_INV, {2'b00, inv, 5'h00}, 4'hf, RESP_OKAY);
      pin(2'd2, 34'({2'b00, pick(c, src, lvl) ^ inv}));
    end
    // Divided clocks: 16 input rises give exactly 4 pad rises
    src <= '0;
    for (int j = 0; j < 2; j++) begin
      c = j ? C_OSCD4 : C_PLLD4;
      wr(IDX_SEL2, {3'b000, c}, 4'hf, RESP_OKAY);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (32) begin
        repeat (2) @(posedge clk);
        if (j) src.osc_clk <= ~src.osc_clk;
        else src.pll_clk <= ~src.pll_clk;
      end
      pin(2'd3, 34'd4);
    end
    results();
  end
endmodule : gsm_pin_mux_tb_top
